// >>> pmt_timer.sv
// Contract
// RULE1 - count and period registers are 8 bits, readable and writable any time
// RULE2 - count rises from 00h to period, next tick returns it to 00h
// RULE3 - reset loads period register with FFh
// RULE4 - reset clears count register
// RULE5 - counter input is instruction clock through a 1, 4 or 16 prescaler
// RULE6 - prescale field 00 divides by 1, 01 by 4, 1x by 16
// RULE7 - matches feed a 4-bit postscaler that sets the interrupt flag
// RULE8 - postscale field in control bits 6..3 gives ratio value plus one
// RULE9 - count write, control write and reset clear prescaler and postscaler
// RULE10 - control write leaves the count unchanged
// RULE11 - control bit 2 runs the timer when set, stops it when clear
// RULE12 - after reset the timer is off and control reads zero
// RULE13 - control bit 7 is unimplemented and reads zero
// RULE14 - pre-postscaler match goes out as serial port shift clock source
// RULE15 - count and match go out as time base for the PWM unit
// RULE16 - postscaled match latches in a flag until software clears it
// RULE17 - while stopped, counters hold and no match or flag occurs
`timescale 1ns/1ps
`default_nettype none
`include "pmt_cfg.svh"

module pmt_timer
    import pmt_pkg::*;
#(
    parameter int COUNT_W = 8,
    parameter int POST_W = 4
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq,
    output logic period_match,
    output logic [7:0] timer_count_out
);

    generate
        if (COUNT_W != 8 || POST_W != 4) begin : g_bad_width
            $error("pmt_timer: only an 8-bit count and 4-bit postscaler are served");
        end
    endgenerate

    pmt_tick_if tk ();

    pmt_ctrl_type control_ff;
    pmt_byte_type count_ff;
    pmt_byte_type period_ff;
    logic [3:0] post_cnt_ff;
    logic [1:0] status_ff;
    logic [1:0] mask_ff;
    logic match_ff;

    logic aw_held_ff;
    logic w_held_ff;
    logic [7:0] awaddr_ff;
    logic [7:0] wdata_ff;
    logic wstrb0_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    pmt_rd_state_type rd_state_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;

    logic do_write;
    logic wr_ok;
    logic wr_control;
    logic wr_count;
    logic wr_period;
    logic wr_status;
    logic wr_mask;
    logic ar_take;
    logic match_now;
    logic post_evt;
    logic [1:0] nxt_status;
    logic [31:0] nxt_rdata;
    logic [1:0] nxt_rresp;

    // ---------------- write channel ----------------
    assign s_axi_awready = !aw_held_ff && !bvalid_ff;
    assign s_axi_wready = !w_held_ff && !bvalid_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            awaddr_ff <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held_ff <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_ff <= 1'b0;
            wdata_ff <= 8'h00;
            wstrb0_ff <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_ff <= 1'b1;
            wdata_ff <= s_axi_wdata[7:0];
            wstrb0_ff <= s_axi_wstrb[0];
        end else if (do_write) begin
            w_held_ff <= 1'b0;
        end
    end

    // registers live in byte lane 0; other lanes are ignored
    always_comb begin
        wr_ok = 1'b1;
        wr_control = 1'b0;
        wr_count = 1'b0;
        wr_period = 1'b0;
        wr_status = 1'b0;
        wr_mask = 1'b0;
        if (awaddr_ff == `PMT_ADDR_CONTROL) begin
            wr_control = do_write && wstrb0_ff;
        end else if (awaddr_ff == `PMT_ADDR_COUNT) begin
            wr_count = do_write && wstrb0_ff;
        end else if (awaddr_ff == `PMT_ADDR_PERIOD) begin
            wr_period = do_write && wstrb0_ff;
        end else if (awaddr_ff == `PMT_ADDR_STATUS) begin
            wr_status = do_write && wstrb0_ff;
        end else if (awaddr_ff == `PMT_ADDR_MASK) begin
            wr_mask = do_write && wstrb0_ff;
        end else begin
            wr_ok = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= `PMT_RESP_OKAY;
        end else if (do_write) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_ok ? `PMT_RESP_OKAY : `PMT_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // ---------------- read channel ----------------
    assign s_axi_arready = (rd_state_ff == PMT_RD_IDLE);
    assign s_axi_rvalid = (rd_state_ff == PMT_RD_VALID);
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign ar_take = s_axi_arvalid && s_axi_arready;

    always_comb begin
        nxt_rdata = 32'h0000_0000;
        nxt_rresp = `PMT_RESP_OKAY;
        if (s_axi_araddr == `PMT_ADDR_CONTROL) begin
            nxt_rdata[6:0] = control_ff; // RULE13
        end else if (s_axi_araddr == `PMT_ADDR_COUNT) begin
            nxt_rdata[7:0] = count_ff; // RULE1
        end else if (s_axi_araddr == `PMT_ADDR_PERIOD) begin
            nxt_rdata[7:0] = period_ff; // RULE1
        end else if (s_axi_araddr == `PMT_ADDR_STATUS) begin
            nxt_rdata[1:0] = status_ff;
        end else if (s_axi_araddr == `PMT_ADDR_MASK) begin
            nxt_rdata[1:0] = mask_ff;
        end else begin
            nxt_rresp = `PMT_RESP_SLVERR;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state_ff <= PMT_RD_IDLE;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= `PMT_RESP_OKAY;
        end else begin
            case (rd_state_ff)
                PMT_RD_IDLE: begin
                    if (ar_take) begin
                        rd_state_ff <= PMT_RD_VALID;
                        rdata_ff <= nxt_rdata;
                        rresp_ff <= nxt_rresp;
                    end
                end
                PMT_RD_VALID: begin
                    if (s_axi_rready) begin
                        rd_state_ff <= PMT_RD_IDLE;
                    end
                end
                default: begin
                    rd_state_ff <= PMT_RD_IDLE;
                end
            endcase
        end
    end

    // ---------------- control and period ----------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            control_ff <= `PMT_RST_CONTROL; // RULE12
        end else if (wr_control) begin
            control_ff <= wdata_ff[`PMT_CTL_POST_MSB:`PMT_CTL_PRE_LSB];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            period_ff <= `PMT_RST_PERIOD; // RULE3
        end else if (wr_period) begin
            period_ff <= wdata_ff;
        end
    end

    // ---------------- prescaler ----------------
    assign tk.run = control_ff.timer_run; // RULE11
    assign tk.sel = control_ff.prescale_select;
    assign tk.clr = wr_control || wr_count; // RULE9

    pmt_prescaler #(
        .INST_DIV(`PMT_INST_DIV)
    ) u_pre (
        .aclk(aclk),
        .aresetn(aresetn),
        .tk(tk.pre)
    );

    // ---------------- count and match ----------------
    // tick is already gated by run and by the clear
    assign match_now = tk.tick && (count_ff == period_ff) && !wr_count;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_ff <= `PMT_RST_COUNT; // RULE4
        end else if (wr_count) begin
            count_ff <= wdata_ff; // RULE1
        end else if (tk.tick) begin // RULE10
            if (count_ff == period_ff) begin
                count_ff <= 8'h00; // RULE2
            end else begin
                count_ff <= count_ff + 8'h01;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            match_ff <= 1'b0;
        end else begin
            match_ff <= match_now; // RULE14
        end
    end

    // one shared pulse: serial port shift clock and PWM time base
    assign period_match = match_ff; // RULE14
    assign timer_count_out = count_ff; // RULE15

    // ---------------- postscaler ----------------
    assign post_evt = match_now && (post_cnt_ff == control_ff.postscale_select); // RULE8

    always_ff @(posedge aclk) begin
        if (!aresetn || tk.clr) begin
            post_cnt_ff <= 4'h0; // RULE9
        end else if (post_evt) begin
            post_cnt_ff <= 4'h0;
        end else if (match_now) begin
            post_cnt_ff <= post_cnt_ff + 4'h1; // RULE7
        end
    end

    // ---------------- interrupt status ----------------
    // set wins over a same-cycle clear so no event is lost
    always_comb begin
        nxt_status = status_ff;
        if (wr_status) begin
            nxt_status = status_ff & ~wdata_ff[1:0];
        end
        nxt_status[`PMT_ST_FLAG_BIT] = nxt_status[`PMT_ST_FLAG_BIT] | post_evt; // RULE16
        nxt_status[`PMT_ST_MATCH_BIT] = nxt_status[`PMT_ST_MATCH_BIT] | match_now;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_ff <= `PMT_RST_STATUS;
        end else begin
            status_ff <= nxt_status;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask_ff <= `PMT_RST_MASK;
        end else if (wr_mask) begin
            mask_ff <= wdata_ff[1:0];
        end
    end

    assign irq = |(status_ff & mask_ff);

    // ---------------- checks ----------------
    sequence s_wrap;
        tk.tick && count_ff == period_ff && !wr_count;
    endsequence

    sequence s_step;
        tk.tick && count_ff != period_ff && !wr_count;
    endsequence

    AST_WRAP_TO_ZERO: assert property (@(posedge aclk) disable iff (!aresetn) // RULE2
        s_wrap |=> count_ff == 8'h00 ##0 period_match)
        else $error("count did not return to zero on match");

    AST_STEP_UP: assert property (@(posedge aclk) disable iff (!aresetn) // RULE2
        s_step |=> count_ff == $past(count_ff) + 8'h01 && !period_match)
        else $error("count did not advance by one");

    AST_RESET_STATE: assert property (@(posedge aclk) disable iff (!aresetn) // RULE12
        $rose(aresetn) |-> count_ff == 8'h00 && period_ff == 8'hFF && control_ff == 7'h00)
        else $error("wrong state after reset");

    AST_POST_STEP: assert property (@(posedge aclk) disable iff (!aresetn) // RULE7
        match_now && post_cnt_ff != control_ff.postscale_select
            |=> post_cnt_ff == $past(post_cnt_ff) + 4'h1)
        else $error("postscaler did not count a match");

    AST_POST_RATIO: assert property (@(posedge aclk) disable iff (!aresetn) // RULE8
        post_evt |=> post_cnt_ff == 4'h0 && status_ff[`PMT_ST_FLAG_BIT])
        else $error("flag or postscaler wrong at final match");

    AST_CLEAR_POST: assert property (@(posedge aclk) disable iff (!aresetn) // RULE9
        wr_control || wr_count |=> post_cnt_ff == 4'h0)
        else $error("postscaler not cleared by write");

    AST_CTRL_KEEPS_COUNT: assert property (@(posedge aclk) disable iff (!aresetn) // RULE10
        wr_control && !wr_count |=> count_ff == $past(count_ff))
        else $error("control write moved the count");

    AST_STOPPED_HOLD: assert property (@(posedge aclk) disable iff (!aresetn) // RULE17
        !control_ff.timer_run && !wr_count |=> count_ff == $past(count_ff) && !period_match
            && !$rose(status_ff[`PMT_ST_FLAG_BIT]))
        else $error("stopped timer changed");

    AST_BIT7_ZERO: assert property (@(posedge aclk) disable iff (!aresetn) // RULE13
        ar_take && s_axi_araddr == `PMT_ADDR_CONTROL |=> s_axi_rvalid && s_axi_rdata[31:7] == 25'h0)
        else $error("control upper bits not zero");

    AST_FLAG_STICKY: assert property (@(posedge aclk) disable iff (!aresetn) // RULE16
        post_evt ##1 !(wr_status && wdata_ff[0]) [*2] |-> status_ff[`PMT_ST_FLAG_BIT])
        else $error("flag lost before software clear");

    AST_MATCH_NEEDS_RUN: assert property (@(posedge aclk) disable iff (!aresetn) // RULE11
        period_match |-> $past(control_ff.timer_run))
        else $error("match while timer off");

endmodule

`default_nettype wire

// >>> pmt_cfg.svh
`ifndef PMT_CFG_SVH
`define PMT_CFG_SVH

// register byte addresses
`define PMT_ADDR_CONTROL 8'h00
`define PMT_ADDR_COUNT 8'h04
`define PMT_ADDR_PERIOD 8'h08
`define PMT_ADDR_STATUS 8'h0C
`define PMT_ADDR_MASK 8'h10

// control field positions
`define PMT_CTL_PRE_LSB 0
`define PMT_CTL_PRE_MSB 1
`define PMT_CTL_RUN_BIT 2
`define PMT_CTL_POST_LSB 3
`define PMT_CTL_POST_MSB 6
`define PMT_CTL_UNUSED_BIT 7

// status and mask bit positions
`define PMT_ST_FLAG_BIT 0
`define PMT_ST_MATCH_BIT 1

// reset values
`define PMT_RST_CONTROL 7'h00
`define PMT_RST_COUNT 8'h00
`define PMT_RST_PERIOD 8'hFF
`define PMT_RST_STATUS 2'h0
`define PMT_RST_MASK 2'h0

// instruction cycle is four oscillator clocks
`define PMT_INST_DIV 4
// prescaler terminal counts for ratios 1, 4 and 16
`define PMT_PRE_TERM_1 4'h0
`define PMT_PRE_TERM_4 4'h3
`define PMT_PRE_TERM_16 4'hF

`define PMT_RESP_OKAY 2'h0
`define PMT_RESP_SLVERR 2'h2

`endif

// >>> pmt_pkg.sv
`default_nettype none

package pmt_pkg;

    typedef logic [7:0] pmt_byte_type;

    typedef struct packed {
        logic [3:0] postscale_select;
        logic timer_run;
        logic [1:0] prescale_select;
    } pmt_ctrl_type;

    typedef enum logic [0:0] {
        PMT_RD_IDLE,
        PMT_RD_VALID
    } pmt_rd_state_type;

endpackage

`default_nettype wire

// >>> pmt_tick_if.sv
`timescale 1ns/1ps
`default_nettype none

interface pmt_tick_if;
    logic run;
    logic clr;
    logic [1:0] sel;
    logic tick;

    modport ctrl (output run, output clr, output sel, input tick);
    modport pre (input run, input clr, input sel, output tick);
endinterface

`default_nettype wire

// >>> pmt_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmt_cfg.svh"

module pmt_prescaler
    import pmt_pkg::*;
#(
    parameter int INST_DIV = `PMT_INST_DIV
) (
    input wire logic aclk,
    input wire logic aresetn,
    pmt_tick_if.pre tk
);

    localparam int DW = (INST_DIV > 1) ? $clog2(INST_DIV) : 1;
    localparam logic [DW-1:0] INST_LAST = DW'(INST_DIV - 1);

    generate
        if (INST_DIV < 2) begin : g_bad_div
            $error("pmt_prescaler: INST_DIV must be at least 2");
        end
    endgenerate

    logic [DW-1:0] inst_cnt_ff;
    logic [3:0] pre_cnt_ff;
    logic [3:0] pre_term;
    logic inst_tick;

    // instruction-cycle divider runs free; it belongs to the core clock
    assign inst_tick = (inst_cnt_ff == INST_LAST);

    always_ff @(posedge aclk) begin
        if (!aresetn || inst_tick) begin
            inst_cnt_ff <= '0;
        end else begin
            inst_cnt_ff <= inst_cnt_ff + DW'(1);
        end
    end

    always_comb begin
        if (tk.sel[1]) begin // RULE6
            pre_term = `PMT_PRE_TERM_16;
        end else if (tk.sel[0]) begin
            pre_term = `PMT_PRE_TERM_4;
        end else begin
            pre_term = `PMT_PRE_TERM_1;
        end
    end

    // a clear masks the tick so a control write never moves the count
    assign tk.tick = inst_tick && tk.run && !tk.clr && (pre_cnt_ff == pre_term); // RULE5

    always_ff @(posedge aclk) begin
        if (!aresetn || tk.clr) begin // RULE9
            pre_cnt_ff <= 4'h0;
        end else if (inst_tick && tk.run) begin // RULE17
            if (pre_cnt_ff >= pre_term) begin
                pre_cnt_ff <= 4'h0;
            end else begin
                pre_cnt_ff <= pre_cnt_ff + 4'h1;
            end
        end
    end

    AST_PRE_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn) // RULE9
        tk.clr |=> pre_cnt_ff == 4'h0)
        else $error("prescaler not cleared");

    AST_PRE_DIV1_GAP: assert property (@(posedge aclk) disable iff (!aresetn) // RULE5
        tk.tick && tk.sel == 2'b00 |=> !tk.tick [*3])
        else $error("instruction tick faster than one in four");

    // a clear restarts the ratio, so a gap attempt spanning one is dropped
    AST_PRE_DIV4_GAP: assert property (@(posedge aclk) disable iff (!aresetn || tk.clr) // RULE6
        tk.tick && tk.sel == 2'b01 && $stable(tk.sel) |=> !tk.tick [*8])
        else $error("prescale 4 tick too early");

    AST_PRE_HOLD: assert property (@(posedge aclk) disable iff (!aresetn) // RULE17
        !tk.run && !tk.clr |=> pre_cnt_ff == $past(pre_cnt_ff) && !tk.tick)
        else $error("prescaler moved while stopped");

endmodule

`default_nettype wire

// >>> pmt_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmt_cfg.svh"

module pmt_timer_tb;
    logic aclk;
    logic aresetn;
    logic [7:0] awaddr;
    logic awvalid;
    logic awready;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic [7:0] araddr;
    logic arvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic irq;
    logic period_match;
    logic [7:0] timer_count_out;
    logic aw_hs, w_hs, b_hs, ar_hs, r_hs;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;
    int errors = 0;
    int checks = 0;

    pmt_timer i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .irq(irq),
        .period_match(period_match), .timer_count_out(timer_count_out));

    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    // handshakes as seen at the edge, readable just after it without a race
    always @(posedge aclk) begin
        aw_hs <= awvalid && awready;
        w_hs <= wvalid && wready;
        b_hs <= bvalid;
        ar_hs <= arvalid && arready;
        r_hs <= rvalid;
        bresp_q <= bresp;
        rresp_q <= rresp;
        rdata_q <= rdata;
    end

    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                             output logic [1:0] resp);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        // only the watchdog ends a wait for the response
        do begin
            @(posedge aclk);
            #1;
            if (aw_hs) awvalid <= 1'b0;
            if (w_hs) wvalid <= 1'b0;
        end while (!b_hs);
        resp = bresp_q;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_write(a, d, 4'hF, r);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            #1;
            if (ar_hs) arvalid <= 1'b0;
        end while (!r_hs);
        d = rdata_q;
        resp = rresp_q;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        check(d, exp);
    endtask

    // cycles until the next match pulse, sampled just after each edge
    task automatic wait_match(output int cyc);
        cyc = 0;
        do begin
            @(posedge aclk);
            #1;
            cyc++;
        end while (period_match !== 1'b1 && cyc < 3000);
    endtask

    function automatic logic [31:0] ctl(input logic [3:0] post, input logic run,
                                        input logic [1:0] pre);
        return {24'h0, 1'b0, post, run, pre};
    endfunction

    task automatic chk_reset_vals();
        rd_chk(`PMT_ADDR_CONTROL, 32'h0000_0000);
        rd_chk(`PMT_ADDR_COUNT, 32'h0000_0000);
        rd_chk(`PMT_ADDR_PERIOD, 32'h0000_00FF);
        rd_chk(`PMT_ADDR_STATUS, 32'h0000_0000);
        rd_chk(`PMT_ADDR_MASK, 32'h0000_0000);
        check({31'h0, irq}, 32'h0000_0000);
    endtask

    initial begin
        repeat (30000) @(posedge aclk);
        errors++;
        report_and_stop();
    end

    initial begin
        logic [31:0] d, d2;
        logic [1:0] r;
        int c, n, k;
        logic [3:0] posts [3];
        posts = '{4'h0, 4'h4, 4'hF};
        aresetn = 1'b0;
        awaddr = 8'h00;
        awvalid = 1'b0;
        wdata = 32'h0;
        wstrb = 4'h0;
        wvalid = 1'b0;
        araddr = 8'h00;
        arvalid = 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        #1;
        chk_reset_vals();
        wr(`PMT_ADDR_PERIOD, 32'hA5A5_A55A);
        rd_chk(`PMT_ADDR_PERIOD, 32'h0000_005A);
        wr(`PMT_ADDR_COUNT, 32'h0000_0033);
        rd_chk(`PMT_ADDR_COUNT, 32'h0000_0033);
        // a write with no byte enabled must leave the register alone
        axi_write(`PMT_ADDR_PERIOD, 32'h0000_0011, 4'h0, r);
        rd_chk(`PMT_ADDR_PERIOD, 32'h0000_005A);
        wr(`PMT_ADDR_CONTROL, ctl(4'hF, 1'b0, 2'h3));
        rd_chk(`PMT_ADDR_COUNT, 32'h0000_0033);
        rd_chk(`PMT_ADDR_CONTROL, 32'h0000_007B);
        check({24'h0, timer_count_out}, 32'h0000_0033);
        wr(`PMT_ADDR_CONTROL, 32'h0000_00FF);
        rd_chk(`PMT_ADDR_CONTROL, 32'h0000_007F);
        rd(8'h14, d, r);
        check({30'h0, r}, {30'h0, `PMT_RESP_SLVERR});
        check(d, 32'h0);
        axi_write(8'h14, 32'h1, 4'hF, r);
        check({30'h0, r}, {30'h0, `PMT_RESP_SLVERR});
        // match interval: (period + 1) ticks of 4 aclk times the prescale ratio
        wr(`PMT_ADDR_PERIOD, 32'h2);
        for (int p = 0; p < 4; p++) begin
            wr(`PMT_ADDR_CONTROL, ctl(4'h0, 1'b1, p[1:0]));
            wait_match(c);
            wait_match(c);
            check(c, 12 * (p == 0 ? 1 : (p == 1 ? 4 : 16)));
        end
        wr(`PMT_ADDR_CONTROL, ctl(4'h0, 1'b0, 2'h0));
        rd(`PMT_ADDR_COUNT, d, r);
        n = 0;
        repeat (100) begin
            @(posedge aclk);
            #1;
            if (period_match === 1'b1) n++;
        end
        rd(`PMT_ADDR_COUNT, d2, r);
        check(d2, d);
        check(n, 0);
        // postscaler: flag after post+1 matches, counted from the control write
        wr(`PMT_ADDR_PERIOD, 32'h1);
        wr(`PMT_ADDR_MASK, 32'h1);
        foreach (posts[i]) begin
            wr(`PMT_ADDR_COUNT, 32'h0);
            wr(`PMT_ADDR_STATUS, 32'h3);
            check({31'h0, irq}, 32'h0);
            wr(`PMT_ADDR_CONTROL, ctl(posts[i], 1'b1, 2'h0));
            n = 0;
            k = 0;
            while (irq !== 1'b1 && k < 3000) begin
                @(posedge aclk);
                #1;
                if (period_match === 1'b1) n++;
                k++;
            end
            @(posedge aclk);
            #1;
            if (period_match === 1'b1) n++;
            wr(`PMT_ADDR_CONTROL, ctl(4'h0, 1'b0, 2'h0));
            check(n, posts[i] + 1);
            rd_chk(`PMT_ADDR_STATUS, 32'h3);
            wr(`PMT_ADDR_MASK, 32'h0);
            check({31'h0, irq}, 32'h0);
            wr(`PMT_ADDR_MASK, 32'h1);
            check({31'h0, irq}, 32'h1);
        end
        // count write clears the 1:16 prescaler, so the next tick is a full ratio away
        wr(`PMT_ADDR_PERIOD, 32'h0);
        wr(`PMT_ADDR_CONTROL, ctl(4'h0, 1'b1, 2'h2));
        wait_match(c);
        repeat (30) @(posedge aclk);
        #1;
        wr(`PMT_ADDR_COUNT, 32'h0);
        wait_match(c);
        check(c >= 50 && c <= 75, 1'b1);
        // a second reset in mid-run restores every register
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        #1;
        chk_reset_vals();
        report_and_stop();
    end
endmodule

`default_nettype wire
